//--- rtl/skip_table_logic_defs.vh
// constants for the skip, table, subtract and xor execution unit
`ifndef SKIP_TABLE_LOGIC_DEFS_VH
`define SKIP_TABLE_LOGIC_DEFS_VH
// operation codes on i_op
`define OP_NONE        5'h00
`define OP_INC_SKIP    5'h01
`define OP_INCA_SKIP   5'h02
`define OP_BIT_SKIP_NZ 5'h03
`define OP_BIT_SKIP_Z  5'h04
`define OP_BYTE_SKIP_NZ 5'h05
`define OP_BYTE_SKIP_Z 5'h06
`define OP_SUB_MEM     5'h07
`define OP_SUB_TO_MEM  5'h08
`define OP_SUB_IMM     5'h09
`define OP_SWAP        5'h0a
`define OP_SWAP_ACC    5'h0b
`define OP_COPY_SKIP_Z 5'h0c
`define OP_TAB_PAGED   5'h0d
`define OP_TAB_LAST    5'h0e
`define OP_ITAB_PAGED  5'h0f
`define OP_ITAB_LAST   5'h10
`define OP_XOR_MEM     5'h11
`define OP_XOR_TO_MEM  5'h12
`define OP_XOR_IMM     5'h13
// software register port map
`define REG_ACC        4'h0
`define REG_PTR_LOW    4'h1
`define REG_PTR_HIGH   4'h2
`define REG_HIGH_BYTE  4'h3
`define REG_FLAGS      4'h4
// flag field positions in the flags register
`define FLAG_C   0
`define FLAG_AC  1
`define FLAG_Z   2
`define FLAG_OV  3
`define FLAG_SC  4
`define FLAG_CZ  5
// reset values
`define RST_BYTE 8'h00
`define RST_FLAGS 6'h00
`endif

//--- rtl/skip_table_logic.v
// execution unit for skip, table read, subtract, swap and xor instructions
// Notes on behaviour
// - increment memory byte, skip when zero
// - accumulator gets byte plus one, skip zero
// - skips take two cycles with dummy
// - bit set skips following instruction
// - bit clear skips following instruction
// - byte test rewrites value, skip zero/nonzero
// - carry set unless subtraction negative
// - subtraction updates all six flags
// - difference stored to memory, not accumulator
// - immediate subtraction into accumulator
// - nibble swap in memory, flags kept
// - swapped byte into accumulator only
// - copy byte to accumulator, skip zero
// - paged table read, low/high split
// - last page read uses low pointer
// - pre-increment low pointer, paged read
// - pre-increment, last page read, no flags
// - xor memory into accumulator, zero flag
// - xor result back to memory, zero flag
// - xor immediate into accumulator, zero flag
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "skip_table_logic_defs.vh"
`default_nettype none
module skip_table_logic #(
  parameter PROG_AW = 12
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // instruction issue
  input wire i_start,
  input wire [4:0] i_op,
  input wire [2:0] i_bit_sel,
  input wire [7:0] i_imm,
  // data memory operand
  input wire [7:0] i_mem_rdata,
  output reg o_mem_we,
  output reg [7:0] o_mem_wdata,
  // program memory table port
  output reg o_prog_re,
  output reg [PROG_AW-1:0] o_prog_addr,
  input wire [15:0] i_prog_rdata,
  // sequencing
  output wire o_busy,
  output reg o_skip,
  output reg o_done,
  // register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // state for observation
  output wire [7:0] o_acc,
  output wire [5:0] o_flags
);
  localparam ST_IDLE = 3'b001;
  localparam ST_TAB = 3'b010;
  localparam ST_DUMMY = 3'b100;

  reg [2:0] state;
  reg [7:0] acc;
  reg [7:0] ptr_low;
  reg [7:0] ptr_high;
  reg [7:0] high_byte;
  reg [5:0] flags;
  reg tab_last;

  reg [7:0] next_acc;
  reg [7:0] next_ptr_low;
  reg [5:0] next_flags;
  reg [7:0] res;
  reg mem_we_c;
  reg do_skip;
  reg do_tab;
  reg [8:0] diff;
  reg [4:0] ndiff;

  assign o_acc = acc;
  assign o_flags = flags;
  assign o_busy = (state != ST_IDLE);

  // zero test used by skips and flag updates
  function is_null;
    input [7:0] v;
    begin
      is_null = (v == 8'h00);
    end
  endfunction

  // table address: paged uses both bytes, last page forces top bits high
  function [PROG_AW-1:0] tab_addr;
    input last;
    input [7:0] hi;
    input [7:0] lo;
    reg [15:0] full;
    begin
      full = last ? {8'hff, lo} : {hi, lo};
      tab_addr = full[PROG_AW-1:0];
    end
  endfunction

  // decode and compute one instruction
  always @* begin
    next_acc = acc;
    next_ptr_low = ptr_low;
    next_flags = flags;
    res = i_mem_rdata;
    mem_we_c = 1'b0;
    do_skip = 1'b0;
    do_tab = 1'b0;
    diff = {1'b0, acc} - {1'b0, (i_op == `OP_SUB_IMM) ? i_imm : i_mem_rdata};
    ndiff = {1'b0, acc[3:0]} -
      {1'b0, (i_op == `OP_SUB_IMM) ? i_imm[3:0] : i_mem_rdata[3:0]};
    if (i_start && state == ST_IDLE) begin
      case (i_op)
        `OP_INC_SKIP: begin
          res = i_mem_rdata + 8'h01;
          mem_we_c = 1'b1;
          do_skip = is_null(res);
        end
        `OP_INCA_SKIP: begin
          res = i_mem_rdata + 8'h01;
          next_acc = res;
          do_skip = is_null(res);
        end
        `OP_BIT_SKIP_NZ: do_skip = i_mem_rdata[i_bit_sel];
        `OP_BIT_SKIP_Z: do_skip = ~i_mem_rdata[i_bit_sel];
        `OP_BYTE_SKIP_NZ: begin
          mem_we_c = 1'b1;
          do_skip = ~is_null(i_mem_rdata);
        end
        `OP_BYTE_SKIP_Z: begin
          mem_we_c = 1'b1;
          do_skip = is_null(i_mem_rdata);
        end
        `OP_SUB_MEM, `OP_SUB_TO_MEM, `OP_SUB_IMM: begin
          res = diff[7:0];
          next_flags[`FLAG_C] = ~diff[8];
          next_flags[`FLAG_AC] = ~ndiff[4];
          next_flags[`FLAG_Z] = is_null(res);
          next_flags[`FLAG_CZ] = is_null(res);
          next_flags[`FLAG_OV] = (acc[7] != res[7]) &&
            (acc[7] != ((i_op == `OP_SUB_IMM) ? i_imm[7] : i_mem_rdata[7]));
          next_flags[`FLAG_SC] = res[7] ^ next_flags[`FLAG_OV];
          if (i_op == `OP_SUB_TO_MEM)
            mem_we_c = 1'b1;
          else
            next_acc = res;
        end
        `OP_SWAP: begin
          res = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
          mem_we_c = 1'b1;
        end
        `OP_SWAP_ACC: next_acc = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
        `OP_COPY_SKIP_Z: begin
          next_acc = i_mem_rdata;
          do_skip = is_null(i_mem_rdata);
        end
        `OP_TAB_PAGED, `OP_TAB_LAST: do_tab = 1'b1;
        `OP_ITAB_PAGED, `OP_ITAB_LAST: begin
          next_ptr_low = ptr_low + 8'h01;
          do_tab = 1'b1;
        end
        `OP_XOR_MEM, `OP_XOR_IMM: begin
          next_acc = acc ^ ((i_op == `OP_XOR_IMM) ? i_imm : i_mem_rdata);
          next_flags[`FLAG_Z] = is_null(next_acc);
        end
        `OP_XOR_TO_MEM: begin
          res = acc ^ i_mem_rdata;
          mem_we_c = 1'b1;
          next_flags[`FLAG_Z] = is_null(res);
        end
        default: ;
      endcase
    end
  end

  // sequencer and architectural state
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      acc <= `RST_BYTE;
      ptr_low <= `RST_BYTE;
      ptr_high <= `RST_BYTE;
      high_byte <= `RST_BYTE;
      flags <= `RST_FLAGS;
      tab_last <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_wdata <= `RST_BYTE;
      o_prog_re <= 1'b0;
      o_prog_addr <= {PROG_AW{1'b0}};
      o_skip <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= `RST_BYTE;
    end else begin
      o_mem_we <= 1'b0;
      o_prog_re <= 1'b0;
      o_skip <= 1'b0;
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            acc <= next_acc;
            ptr_low <= next_ptr_low;
            flags <= next_flags;
            o_mem_we <= mem_we_c;
            o_mem_wdata <= res;
            if (do_tab) begin
              // the updated pointer forms the address
              tab_last <= (i_op == `OP_TAB_LAST) || (i_op == `OP_ITAB_LAST);
              o_prog_re <= 1'b1;
              o_prog_addr <= tab_addr((i_op == `OP_TAB_LAST) ||
                (i_op == `OP_ITAB_LAST), ptr_high, next_ptr_low);
              state <= ST_TAB;
            end else if (do_skip) begin
              // dummy cycle replaces the skipped instruction
              o_skip <= 1'b1;
              state <= ST_DUMMY;
            end else begin
              o_done <= 1'b1;
            end
          end
        end
        ST_TAB: begin
          // low byte to memory, high byte held here
          o_mem_we <= 1'b1;
          o_mem_wdata <= i_prog_rdata[7:0];
          high_byte <= i_prog_rdata[15:8];
          o_done <= 1'b1;
          state <= ST_IDLE;
        end
        ST_DUMMY: begin
          o_done <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // software writes lose to the instruction in flight
      if (i_wr && !(i_start && state == ST_IDLE)) begin
        if (i_addr == `REG_ACC)
          acc <= i_wdata;
        else if (i_addr == `REG_PTR_LOW)
          ptr_low <= i_wdata;
        else if (i_addr == `REG_PTR_HIGH)
          ptr_high <= i_wdata;
        else if (i_addr == `REG_FLAGS)
          flags <= i_wdata[5:0];
      end
      // read data the cycle after the strobe; unmapped reads zero
      if (i_rd) begin
        if (i_addr == `REG_ACC)
          o_rdata <= acc;
        else if (i_addr == `REG_PTR_LOW)
          o_rdata <= ptr_low;
        else if (i_addr == `REG_PTR_HIGH)
          o_rdata <= ptr_high;
        else if (i_addr == `REG_HIGH_BYTE)
          o_rdata <= high_byte;
        else if (i_addr == `REG_FLAGS)
          o_rdata <= {2'b00, flags};
        else
          o_rdata <= 8'h00;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/skip_table_logic_chk.sv
// port checker for the skip, table, subtract and xor unit
`include "skip_table_logic_defs.vh"
`default_nettype none
module skip_table_logic_chk (
  // clock, reset and issue
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [4:0] i_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_imm,
  input wire logic [7:0] i_mem_rdata,
  // results
  input wire logic o_mem_we,
  input wire logic [7:0] o_mem_wdata,
  input wire logic o_busy,
  input wire logic o_skip,
  input wire logic o_done,
  input wire logic [7:0] o_acc,
  input wire logic [5:0] o_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // op code taken this edge; a start while busy is dropped
  wire logic [4:0] go = (i_start && !o_busy) ? i_op : `OP_NONE;
  wire logic bit_v = i_mem_rdata[i_bit_sel];
  wire logic [7:0] swp = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
  AST_INC: assert property (go == `OP_INC_SKIP |=> o_mem_we &&
    o_mem_wdata == $past(i_mem_rdata) + 8'h01 && o_skip == !o_mem_wdata)
    else $error("increment write or skip wrong");
  AST_INCA: assert property (go == `OP_INCA_SKIP |=> !o_mem_we &&
    o_acc == $past(i_mem_rdata) + 8'h01 && o_skip == !o_acc)
    else $error("increment to acc wrong");
  AST_SKIP: assert property (o_skip |-> o_busy ##1 o_done && !o_skip)
    else $error("skip not two cycles");
  AST_BNZ: assert property (go == `OP_BIT_SKIP_NZ |=>
    o_skip == $past(bit_v)) else $error("bit set test wrong");
  AST_BZ: assert property (go == `OP_BIT_SKIP_Z |=>
    o_skip != $past(bit_v)) else $error("bit clear test wrong");
  AST_SUBC: assert property (go == `OP_SUB_IMM |=>
    o_flags[`FLAG_C] == ($past(o_acc) >= $past(i_imm)))
    else $error("subtract carry wrong");
  AST_SWAP: assert property (go == `OP_SWAP |=> o_mem_we &&
    o_mem_wdata == $past(swp) && $stable(o_flags))
    else $error("nibble swap wrong");
  AST_XORI: assert property (go == `OP_XOR_IMM |=>
    o_acc == ($past(o_acc) ^ $past(i_imm)) && o_flags[`FLAG_Z] == !o_acc)
    else $error("xor immediate wrong");
  AST_DIFFERENCE_TO_MEMORY: assert property (go == `OP_SUB_TO_MEM |=> o_mem_we &&
    o_mem_wdata == $past(o_acc) - $past(i_mem_rdata) && $stable(o_acc))
    else $error("difference to memory wrong");
  AST_COPY: assert property (go == `OP_COPY_SKIP_Z |=>
    o_acc == $past(i_mem_rdata) && o_skip == !o_acc)
    else $error("copy and skip wrong");
endmodule
bind skip_table_logic skip_table_logic_chk chk_inst (.i_sys_clk,
  .i_rst_n, .i_start, .i_op, .i_bit_sel, .i_imm, .i_mem_rdata,
  .o_mem_we, .o_mem_wdata, .o_busy, .o_skip, .o_done, .o_acc, .o_flags);
`default_nettype wire

//--- verification/skip_table_logic_tb.sv
// self-checking bench for the skip, table, subtract and xor unit
`include "skip_table_logic_defs.vh"
`default_nettype none
module skip_table_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_rst_n, i_start, i_wr, i_rd;
  logic o_mem_we, o_prog_re, o_busy, o_skip, o_done;
  logic [4:0] i_op;
  logic [2:0] i_bit_sel;
  logic [3:0] i_addr;
  logic [7:0] i_imm, i_mem_rdata, i_wdata, o_mem_wdata, o_rdata, o_acc, wl;
  logic [11:0] o_prog_addr;
  logic [15:0] i_prog_rdata, pw;
  logic [5:0] o_flags;
  int error_cnt = 0, checked = 0, wn = 0, sn = 0, n;
  // table word answers only while read; otherwise inverted
  assign pw = {4'ha, o_prog_addr};
  assign i_prog_rdata = o_prog_re ? pw : ~pw;
  skip_table_logic skip_table_logic_inst (.i_sys_clk, .i_rst_n, .i_start,
    .i_op, .i_bit_sel, .i_imm, .i_mem_rdata, .o_mem_we, .o_mem_wdata,
    .o_prog_re, .o_prog_addr, .i_prog_rdata, .o_busy, .o_skip, .o_done,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_acc, .o_flags);
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // count memory writes and skips as the design emits them
  always @(posedge i_sys_clk) begin
    if (o_mem_we === 1'b1) begin
      wn <= wn + 1;
      wl <= o_mem_wdata;
    end
    if (o_skip === 1'b1) sn <= sn + 1;
  end
  task automatic ck(input logic [7:0] v, input logic [7:0] e);
    checked++;
    if (v !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    // read data stands only in the cycle after the strobe; look mid-cycle
    @(negedge i_sys_clk);
    ck(o_rdata, e);
    @(posedge i_sys_clk);
  endtask
  // issue one instruction, wait for done, compare the skip count
  task automatic op(input logic [4:0] c, input logic [7:0] m,
    input logic [7:0] x, input int sk);
    int s0;
    s0 = sn;
    i_start <= 1'b1;
    i_op <= c;
    i_mem_rdata <= m;
    i_imm <= x;
    i_bit_sel <= x[2:0];
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    // sample the registered done pulse off the edge that launches it
    for (int k = 0; k < 8; k++) begin
      @(negedge i_sys_clk);
      if (o_done === 1'b1) break;
    end
    if (o_done !== 1'b1) begin
      error_cnt++;
      results();
    end
    // counters have taken the last pulse by the next falling edge
    @(negedge i_sys_clk);
    ck(8'(sn - s0), 8'(sk));
    @(posedge i_sys_clk);
  endtask
  initial begin
    i_rst_n = 1'b0;
    {i_start, i_wr, i_rd, i_op, i_bit_sel, i_imm} = '0;
    {i_mem_rdata, i_addr, i_wdata} = '0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(`REG_FLAGS, 8'h00);
    op(`OP_INC_SKIP, 8'hff, 8'h00, 1);
    ck(wl, 8'h00);
    op(`OP_INC_SKIP, 8'h41, 8'h00, 0);
    n = wn;
    op(`OP_INCA_SKIP, 8'hff, 8'h00, 1);
    ck(8'(wn - n), 8'h00);
    op(`OP_BIT_SKIP_NZ, 8'h08, 8'h03, 1);
    op(`OP_BIT_SKIP_NZ, 8'hf7, 8'h03, 0);
    op(`OP_BIT_SKIP_Z, 8'hf7, 8'h03, 1);
    op(`OP_BIT_SKIP_Z, 8'h08, 8'h03, 0);
    op(`OP_BYTE_SKIP_NZ, 8'h5a, 8'h00, 1);
    ck(wl, 8'h5a);
    op(`OP_BYTE_SKIP_Z, 8'h00, 8'h00, 1);
    op(`OP_BYTE_SKIP_Z, 8'h5a, 8'h00, 0);
    wr(`REG_ACC, 8'h10);
    op(`OP_SUB_MEM, 8'h20, 8'h00, 0);
    ck(o_flags, 8'h12);
    wr(`REG_ACC, 8'h80);
    op(`OP_SUB_IMM, 8'h00, 8'h01, 0);
    ck(o_acc, 8'h7f);
    ck(o_flags, 8'h19);
    op(`OP_SUB_TO_MEM, 8'h7f, 8'h00, 0);
    ck(wl, 8'h00);
    ck(o_flags, 8'h27);
    op(`OP_SWAP, 8'h3c, 8'h00, 0);
    ck(wl, 8'hc3);
    op(`OP_SWAP_ACC, 8'ha5, 8'h00, 0);
    ck(o_acc, 8'h5a);
    op(`OP_COPY_SKIP_Z, 8'h00, 8'h00, 1);
    op(`OP_COPY_SKIP_Z, 8'h09, 8'h00, 0);
    wr(`REG_PTR_LOW, 8'hff);
    wr(`REG_PTR_HIGH, 8'h03);
    op(`OP_TAB_PAGED, 8'h00, 8'h00, 0);
    rd(`REG_HIGH_BYTE, 8'ha3);
    op(`OP_ITAB_PAGED, 8'h00, 8'h00, 0);
    ck(wl, 8'h00);
    wr(`REG_PTR_LOW, 8'h5c);
    op(`OP_TAB_LAST, 8'h00, 8'h00, 0);
    rd(`REG_HIGH_BYTE, 8'haf);
    op(`OP_ITAB_LAST, 8'h00, 8'h00, 0);
    ck(wl, 8'h5d);
    ck(o_flags, 8'h27);
    op(`OP_XOR_MEM, 8'h0f, 8'h00, 0);
    ck(o_flags, 8'h23);
    op(`OP_XOR_TO_MEM, 8'h06, 8'h00, 0);
    ck(o_flags, 8'h27);
    op(`OP_XOR_IMM, 8'h00, 8'hf0, 0);
    ck(o_acc, 8'hf6);
    results();
  end
endmodule
`default_nettype wire
